// ==== hw/pec_params.svh ====
// constants for the cpu performance event counter: offsets, fields,
// reset values and the ratio-weighted step table
// assumes inclusion by the package, the counter module, its checker, the apb master and the bench
`ifndef PEC_PARAMS_SVH
`define PEC_PARAMS_SVH

`define PEC_CNT_W      48
`define PEC_AW         8
// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define PEC_OFS_CTRL0  8'h00
`define PEC_OFS_CTRL1  8'h04
`define PEC_OFS_START  8'h08
`define PEC_OFS_END    8'h0C
`define PEC_OFS_LO0    8'h10
`define PEC_OFS_HI0    8'h14
`define PEC_OFS_LO1    8'h18
`define PEC_OFS_HI1    8'h1C
`define PEC_OFS_STAT   8'h20
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define PEC_CTRL_INIT  8
`define PEC_CTRL_RST   8'h00
`define PEC_PC_RST     32'h0000_0000
// ------------------------------------------------------------
// ratio-weighted steps: step = 24 / (cpu clock / bus clock)
// ------------------------------------------------------------
`define PEC_STEP_DEN   24
`define PEC_RATIO_0    1
`define PEC_RATIO_1    2
`define PEC_RATIO_2    3
`define PEC_RATIO_3    4
`define PEC_RATIO_4    6
`define PEC_RATIO_5    8
`define PEC_FP_NIBBLE  4'hF

`endif

// ==== hw/pec_pkg.sv ====
// types for the cpu performance event counter
// assumes pec_params.svh on the include path
`include "pec_params.svh"

package pec_pkg;

   typedef enum logic [4:0] {
      elapsed_cycle_event       = 5'h00,
      icache_miss_event         = 5'h01,
      data_xlat_miss_event      = 5'h02,
      instr_xlat_miss_event     = 5'h03,
      cacheable_fetch_event     = 5'h04,
      total_fetch_event         = 5'h05,
      issue_event               = 5'h06,
      dual_issue_event          = 5'h07,
      float_issue_event         = 5'h08,
      break_chan_a_match_event  = 5'h09,
      break_chan_b_match_event  = 5'h0A,
      ifetch_miss_freeze_event  = 5'h0B,
      operand_miss_freeze_event = 5'h0C,
      branch_freeze_event       = 5'h0D,
      icache_fill_cycle_event   = 5'h0E,
      operand_access_event      = 5'h0F
   } pec_ev_e;

   typedef struct packed {
      pec_ev_e evsel;
      logic    range_en;
      logic    method;
      logic    enable;
   } pec_ctrl_s;

   typedef struct packed {
      pec_ctrl_s              ctrl;
      logic [`PEC_CNT_W-1:0]  cnt;
      logic                   ovf;
      logic                   in_rng;
   } pec_chan_s;

   // cpu-side event strobes, all on pclk
   typedef struct packed {
      logic        ic_miss;
      logic        ic_slow_uncached;
      logic        ic_overrun_miss;
      logic        dtlb_miss;
      logic        itlb_miss;
      logic        fetch_acc;
      logic        fetch_cacheable;
      logic [1:0]  issue_cnt;
      logic [1:0]  fexc_issue;
      logic [15:0] slot0_op;
      logic [15:0] slot1_op;
      logic [1:0]  slot_fp_xfer;
      logic        break_a;
      logic        break_b;
      logic        ic_freeze;
      logic        op_freeze;
      logic        ram_io_freeze_i;
      logic        ram_io_freeze_d;
      logic        unc_freeze_i;
      logic        unc_freeze_d;
      logic        branch_exec;
      logic        ds_delay;
      logic        br_tgt_stall;
      logic        exc_freeze;
      logic        ic_fill;
      logic        op_access;
      logic        page_cacheable_attr;
      logic        prefetch_instr;
   } pec_evt_s;

   typedef struct packed {
      pec_chan_s [1:0] ch;
      logic [31:0]     start_pc;
      logic [31:0]     end_pc;
      logic            br_stall;
      logic [31:0]     prdata;
      logic            pready;
      logic            pslverr;
   } pec_state_s;

endpackage

// ==== hw/pec_counter.sv ====
// two-channel cpu performance event counter with an apb register slave
// assumes event strobes, pc and ratio code come from logic on pclk

`timescale 1ns/1ns
`include "pec_params.svh"

// Notes on behaviour
// - each channel counts in 48-bit accumulator
// - wrap marks the channel count invalid
// - per-channel choice of plain or weighted method
// - plain method adds the event amount per counted cycle
// - weighted method adds amount times 3,4,6,8,12 or 24
// - optional counting window from start to end pc
// - icache miss includes slow uncached fetches
// - icache miss includes overrun fetch miss
// - translation misses count even when cancelled
// - fetch events count at request acceptance
// - issue and float issue add one for pairs
// - fetch exception adds one to three to issue
// - float issue covers Fxxx and comm/status moves
// - break matches count even used by emulator
// - miss freezes include ram, io, uncached stalls
// - branch freeze one cycle unless slot delayed
// - branch target miss cycles two on go fill
// - prefetch or non-cacheable operands not counted
// - branch freeze counts branch and exception freezes
// - icache fill counts every fill cycle
// - dual issue counts paired issue cycles
module pec_counter #(
   parameter int CNT_W = `PEC_CNT_W
) (
   input  wire logic                pclk,      // cpu operating clock
   input  wire logic                presetn,   // async reset, low
   input  wire logic                psel,      // apb select
   input  wire logic                penable,   // apb access phase
   input  wire logic                pwrite,    // apb direction
   input  wire logic [`PEC_AW-1:0]  paddr,     // apb byte address
   input  wire logic [31:0]         pwdata,    // apb write data
   output logic      [31:0]         prdata,    // apb read data
   output logic                     pready,    // apb ready
   output logic                     pslverr,   // apb error
   input  wire pec_pkg::pec_evt_s   evt,       // cpu event strobes
   input  wire logic                pc_valid,  // pc below is executing
   input  wire logic [31:0]         pc,        // current program address
   input  wire logic [2:0]          ratio_code // cpu to bus clock ratio
);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (CNT_W != `PEC_CNT_W) begin : g_bad_width
      $error("pec_counter: counter width fixed by the state type");
   end

   pec_pkg::pec_state_s q;
   pec_pkg::pec_state_s d;

   // ------------------------------------------------------------
   // event decode
   // ------------------------------------------------------------
   function automatic logic fp_op(input logic [15:0] op,
                                  input logic        xfer);
      fp_op = (op[15:12] == `PEC_FP_NIBBLE) || xfer;
   endfunction

   function automatic logic [1:0] ev_amount(
      input pec_pkg::pec_ev_e sel,
      input pec_pkg::pec_evt_s e,
      input logic             br_prev);
      logic any_issue;
      logic fp0;
      logic fp1;
      any_issue = (e.issue_cnt != 2'd0);
      fp0       = any_issue && fp_op(e.slot0_op, e.slot_fp_xfer[0]);
      fp1       = (e.issue_cnt == 2'd2)
                  && fp_op(e.slot1_op, e.slot_fp_xfer[1]);
      ev_amount = 2'd0;
      case (sel)
         pec_pkg::elapsed_cycle_event:
            ev_amount = 2'd1;
         pec_pkg::icache_miss_event:
            ev_amount = {1'b0, e.ic_miss | e.ic_slow_uncached
                               | e.ic_overrun_miss};
         pec_pkg::data_xlat_miss_event:
            ev_amount = {1'b0, e.dtlb_miss};
         pec_pkg::instr_xlat_miss_event:
            ev_amount = {1'b0, e.itlb_miss};
         pec_pkg::cacheable_fetch_event:
            ev_amount = {1'b0, e.fetch_acc & e.fetch_cacheable};
         pec_pkg::total_fetch_event:
            ev_amount = {1'b0, e.fetch_acc};
         // pairs add one, fetch exceptions 1..3
         pec_pkg::issue_event:
            ev_amount = (e.fexc_issue != 2'd0) ? e.fexc_issue
                        : {1'b0, any_issue};
         pec_pkg::dual_issue_event:
            ev_amount = (e.fexc_issue != 2'd0) ? e.fexc_issue
                        : {1'b0, e.issue_cnt == 2'd2};
         // one per cycle even for two float ops
         pec_pkg::float_issue_event:
            ev_amount = {1'b0, fp0 | fp1};
         // matches are not masked by emulator use
         pec_pkg::break_chan_a_match_event:
            ev_amount = {1'b0, e.break_a};
         pec_pkg::break_chan_b_match_event:
            ev_amount = {1'b0, e.break_b};
         // ram, io and uncached fetch stalls
         pec_pkg::ifetch_miss_freeze_event:
            ev_amount = {1'b0, e.ic_freeze | e.ram_io_freeze_i
                               | e.unc_freeze_i};
         // ram, io and uncached operand stalls
         pec_pkg::operand_miss_freeze_event:
            ev_amount = {1'b0, e.op_freeze | e.ram_io_freeze_d
                               | e.unc_freeze_d};
         pec_pkg::branch_freeze_event:
            ev_amount = {1'b0, (e.branch_exec & ~e.ds_delay)
                               | e.exc_freeze};
         // fill cycles plus target stall past first
         pec_pkg::icache_fill_cycle_event:
            ev_amount = {1'b0, e.ic_fill
                               | (e.br_tgt_stall & br_prev)};
         // prefetch and page_cacheable_attr clear are masked out
         pec_pkg::operand_access_event:
            ev_amount = {1'b0, e.op_access & e.page_cacheable_attr
                               & ~e.prefetch_instr};
         default:
            ev_amount = 2'd0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // ratio-weighted step
   // ------------------------------------------------------------
   // step is 24 divided by the clock ratio
   function automatic logic [4:0] ratio_step(input logic [2:0] c);
      case (c)
         3'd0:    ratio_step = 5'(`PEC_STEP_DEN / `PEC_RATIO_0);
         3'd1:    ratio_step = 5'(`PEC_STEP_DEN / `PEC_RATIO_1);
         3'd2:    ratio_step = 5'(`PEC_STEP_DEN / `PEC_RATIO_2);
         3'd3:    ratio_step = 5'(`PEC_STEP_DEN / `PEC_RATIO_3);
         3'd4:    ratio_step = 5'(`PEC_STEP_DEN / `PEC_RATIO_4);
         3'd5:    ratio_step = 5'(`PEC_STEP_DEN / `PEC_RATIO_5);
         // unknown ratio codes take the slowest bus weight
         default: ratio_step = 5'(`PEC_STEP_DEN / `PEC_RATIO_5);
      endcase
   endfunction

   // ------------------------------------------------------------
   // register read mux
   // ------------------------------------------------------------
   logic [31:0] rd_data;
   logic        rd_hit;

   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      case (paddr)
         `PEC_OFS_CTRL0: rd_data = {24'h00_0000, q.ch[0].ctrl};
         `PEC_OFS_CTRL1: rd_data = {24'h00_0000, q.ch[1].ctrl};
         `PEC_OFS_START: rd_data = q.start_pc;
         `PEC_OFS_END:   rd_data = q.end_pc;
         `PEC_OFS_LO0:   rd_data = q.ch[0].cnt[31:0];
         `PEC_OFS_HI0:   rd_data = {16'h0000, q.ch[0].cnt[47:32]};
         `PEC_OFS_LO1:   rd_data = q.ch[1].cnt[31:0];
         `PEC_OFS_HI1:   rd_data = {16'h0000, q.ch[1].cnt[47:32]};
         // valid bits are the inverse of overflow
         `PEC_OFS_STAT:  rd_data = {26'h000_0000,
                                    q.ch[1].in_rng, q.ch[0].in_rng,
                                    ~q.ch[1].ovf, ~q.ch[0].ovf,
                                    q.ch[1].ovf, q.ch[0].ovf};
         default:        rd_hit  = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic                  wr_done;
   logic [4:0]            step;
   logic [1:0]            amt;
   logic [6:0]            inc;
   logic                  gate;
   logic                  start_hit;
   logic                  end_hit;
   logic [`PEC_CNT_W:0]   sum;

   always_comb begin
      d         = q;
      amt       = 2'd0;
      inc       = 7'd0;
      gate      = 1'b0;
      sum       = '0;
      step      = ratio_step(ratio_code);
      start_hit = pc_valid && (pc == q.start_pc);
      end_hit   = pc_valid && (pc == q.end_pc);
      wr_done   = psel && penable && q.pready && pwrite;

      // apb: answer in the access cycle that follows setup
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      if (psel && !penable) begin
         d.pready  = 1'b1;
         d.pslverr = ~rd_hit;
         d.prdata  = pwrite ? 32'h0000_0000 : rd_data;
      end

      // remember a target stall so only later cycles go to fill
      d.br_stall = evt.br_tgt_stall;

      for (int i = 0; i < 2; i++) begin
         // init clears count and overflow before this cycle adds
         if (wr_done && (paddr == ((i == 0) ? `PEC_OFS_CTRL0
                                            : `PEC_OFS_CTRL1))) begin
            d.ch[i].ctrl = pec_pkg::pec_ctrl_s'(pwdata[7:0]);
            if (pwdata[`PEC_CTRL_INIT]) begin
               d.ch[i].cnt    = '0;
               d.ch[i].ovf    = 1'b0;
               d.ch[i].in_rng = 1'b0;
            end
         end

         // window opens at start pc, closes after end pc
         if (q.ch[i].ctrl.range_en) begin
            if (start_hit) begin
               d.ch[i].in_rng = 1'b1;
            end
            if (end_hit && (q.ch[i].in_rng || start_hit)) begin
               d.ch[i].in_rng = 1'b0;
            end
         end
         gate = q.ch[i].ctrl.enable
                && (!q.ch[i].ctrl.range_en
                    || q.ch[i].in_rng || start_hit);

         amt = ev_amount(q.ch[i].ctrl.evsel, evt, q.br_stall);
         // plain adds the amount, weighted adds amount times the ratio step
         inc = q.ch[i].ctrl.method ? 7'(amt) * 7'(step) : 7'(amt);
         if (gate) begin
            // 48-bit accumulate, carry out is the wrap
            sum = {1'b0, d.ch[i].cnt} + (`PEC_CNT_W+1)'(inc);
            d.ch[i].cnt = sum[`PEC_CNT_W-1:0];
            // wrap sets a sticky invalid mark
            if (sum[`PEC_CNT_W]) begin
               d.ch[i].ovf = 1'b1;
            end
         end
      end

      if (wr_done && (paddr == `PEC_OFS_START)) begin
         d.start_pc = pwdata;
      end
      if (wr_done && (paddr == `PEC_OFS_END)) begin
         d.end_pc = pwdata;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2; i++) begin
            q.ch[i].ctrl   <= pec_pkg::pec_ctrl_s'(`PEC_CTRL_RST);
            q.ch[i].cnt    <= '0;
            q.ch[i].ovf    <= 1'b0;
            q.ch[i].in_rng <= 1'b0;
         end
         q.start_pc <= `PEC_PC_RST;
         q.end_pc   <= `PEC_PC_RST;
         q.br_stall <= 1'b0;
         q.prdata   <= 32'h0000_0000;
         q.pready   <= 1'b0;
         q.pslverr  <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;

endmodule // pec_counter

// ==== verif/pec_counter_props.sv ====
// assertions on the apb side of the performance counter
// assumes a bind onto pec_counter, every apb port watched by name
`timescale 1ns/1ns
`include "pec_params.svh"

module pec_counter_props #(
   parameter int CNT_W = `PEC_CNT_W
) (
   input wire logic               pclk,    // clock
   input wire logic               presetn, // reset, low
   input wire logic               psel,    // select
   input wire logic               penable, // access phase
   input wire logic               pwrite,  // direction
   input wire logic [`PEC_AW-1:0] paddr,   // address
   input wire logic [31:0]        pwdata,  // write data
   input wire logic [31:0]        prdata,  // read data
   input wire logic               pready,  // ready
   input wire logic               pslverr  // error
);
   logic [7:0]  ctl_q [2];
   logic [31:0] spc_q;
   logic        done;
   logic        rd;
   logic        map;
   assign done = psel && penable && pready;
   assign rd   = done && !pwrite;
   assign map  = paddr <= `PEC_OFS_STAT && paddr[1:0] == 2'h0;
   // ------------------------------------------------------------
   // shadow of what software last wrote
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= '{default: 8'h00};
         spc_q <= 32'h0000_0000;
      end else if (done && pwrite) begin
         if (paddr == `PEC_OFS_CTRL0 || paddr == `PEC_OFS_CTRL1)
            ctl_q[paddr[2]] <= pwdata[7:0];
         if (paddr == `PEC_OFS_START)
            spc_q <= pwdata;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   zero_wait_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
      else $error("ready without setup");
   err_map_a: assert property (pready |-> pslverr == !map)
      else $error("error flag wrong for address");
   wr_zero_a: assert property (done && pwrite |-> prdata == 32'h0000_0000)
      else $error("read data during write");
   hi_width_a: assert property (
      rd && (paddr == `PEC_OFS_HI0 || paddr == `PEC_OFS_HI1)
      |-> prdata[31:CNT_W-32] == '0) else $error("count wider than set");
   stat_valid_a: assert property (
      rd && paddr == `PEC_OFS_STAT |-> prdata[3:2] == ~prdata[1:0])
      else $error("valid flag disagrees with overflow");
   ctrl_back_a: assert property (
      rd && (paddr == `PEC_OFS_CTRL0 || paddr == `PEC_OFS_CTRL1)
      |-> prdata == {24'h00_0000, ctl_q[paddr[2]]})
      else $error("control readback wrong");
   start_back_a: assert property (
      rd && paddr == `PEC_OFS_START |-> prdata == spc_q)
      else $error("start address readback wrong");
endmodule // pec_counter_props

bind pec_counter pec_counter_props #(.CNT_W(CNT_W)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// ==== verif/pec_apb_master.sv ====
// apb master standing in for the debug emulator
// assumes one clock; a wait that runs out is flagged to the caller
`timescale 1ns/1ns
`include "pec_params.svh"

module pec_apb_master (
   input  wire logic               pclk,    // clock
   output logic                    psel,    // select
   output logic                    penable, // access phase
   output logic                    pwrite,  // direction
   output logic [`PEC_AW-1:0]      paddr,   // address
   output logic [31:0]             pwdata,  // write data
   input  wire logic [31:0]        prdata,  // read data
   input  wire logic               pready,  // ready
   input  wire logic               pslverr  // error
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // request held until ready is seen at an edge or 16 edges pass, then released
   task automatic xfer(input logic w, input logic [`PEC_AW-1:0] a,
         input logic [31:0] d, output logic [31:0] rd, output logic er,
         output logic to);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      to = 1'b1;
      for (int i = 0; i < 16 && to; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            to = 1'b0;
            rd = prdata;
            er = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // pec_apb_master

// ==== verif/pec_counter_tb_top.sv ====
// self-checking bench: per-cycle reference model against the counter
// assumes pec_pkg, the apb partner and the bound checker are compiled
`timescale 1ns/1ns
`include "pec_params.svh"
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin \
   num_errors++; $display("FAIL %s exp %0h got %0h", n, e, s); end end

module pec_counter_tb_top;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              run = 1'b0;
   logic              pc_valid = 1'b0;
   logic [31:0]       pc = 32'h0;
   logic [2:0]        ratio_code = 3'h0;
   pec_pkg::pec_evt_s evt = '0;
   pec_pkg::pec_evt_s tev;
   logic              psel, penable, pwrite, pready, pslverr, wr;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, ms, me, rd;
   logic [47:0]       mc [2];
   logic [7:0]        mct [2];
   logic              mo [2], mi [2];
   logic              mbr, hs, he, g, ini, er, to;
   pec_pkg::pec_ctrl_s c;
   logic [48:0]       s;
   logic [63:0]       r;
   int                num_errors = 0, n_compared = 0, stp;
   int                rt [6] = '{1, 2, 3, 4, 6, 8};
   logic [7:0]        ad [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                  8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'hFC};
   always #5 pclk = ~pclk;
   assign wr = psel && penable && pready && pwrite;
   pec_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
      .pc_valid(pc_valid), .pc(pc), .ratio_code(ratio_code));
   pec_apb_master m (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   // ------------------------------------------------------------
   // reference amount per event and cycle
   // ------------------------------------------------------------
   function automatic int amt(pec_pkg::pec_ev_e sel, pec_pkg::pec_evt_s e);
      logic f0, f1, fx;
      f0 = e.issue_cnt != 2'h0 && (e.slot0_op[15:12] == 4'hF);
      f1 = e.issue_cnt == 2'h2 && (e.slot1_op[15:12] == 4'hF);
      fx = e.issue_cnt != 2'h0 && e.slot_fp_xfer[0];
      fx = fx || (e.issue_cnt == 2'h2 && e.slot_fp_xfer[1]);
      case (sel)
         5'h01: return e.ic_miss | e.ic_slow_uncached | e.ic_overrun_miss;
         5'h02: return e.dtlb_miss;
         5'h03: return e.itlb_miss;
         5'h04: return e.fetch_acc & e.fetch_cacheable;
         5'h05: return e.fetch_acc;
         5'h06: return e.fexc_issue != 0 ? e.fexc_issue : e.issue_cnt != 0;
         5'h07: return e.fexc_issue != 0 ? e.fexc_issue : e.issue_cnt == 2;
         5'h08: return f0 | f1 | fx;
         5'h09: return e.break_a;
         5'h0A: return e.break_b;
         5'h0B: return e.ic_freeze | e.ram_io_freeze_i | e.unc_freeze_i;
         5'h0C: return e.op_freeze | e.ram_io_freeze_d | e.unc_freeze_d;
         5'h0D: return (e.branch_exec & !e.ds_delay) | e.exc_freeze;
         5'h0E: return e.ic_fill | (e.br_tgt_stall & mbr);
         5'h0F: return e.op_access & e.page_cacheable_attr
                       & !e.prefetch_instr;
         5'h00: return 1;
         // select codes past the list count nothing
         default: return 0;
      endcase
   endfunction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc = '{default: 48'h0};
         mct = '{default: 8'h00};
         mo = '{default: 1'b0};
         mi = '{default: 1'b0};
         {ms, me, mbr} = 65'h0;
      end else begin
         stp = ratio_code > 3'h5 ? 3 : 24 / rt[ratio_code];
         hs = pc_valid && pc == ms;
         he = pc_valid && pc == me;
         for (int i = 0; i < 2; i++) begin
            c = mct[i];
            g = c.enable && (!c.range_en || mi[i] || hs);
            ini = wr && paddr == 8'(4 * i) && pwdata[8];
            s = (ini ? 49'h0 : {1'b0, mc[i]}) +
                49'(g ? amt(c.evsel, evt) * (c.method ? stp : 1) : 0);
            mc[i] <= s[47:0];
            mo[i] <= (mo[i] && !ini) || s[48];
            // window state moves with the window in use, otherwise only init clears it
            mi[i] <= c.range_en ? (mi[i] && !ini || hs) && !he
                                : mi[i] && !ini;
            if (wr && paddr == 8'(4 * i))
               mct[i] <= pwdata[7:0];
         end
         mbr <= evt.br_tgt_stall;
         if (wr && paddr == `PEC_OFS_START)
            ms <= pwdata;
         if (wr && paddr == `PEC_OFS_END)
            me <= pwdata;
      end
   end
   function automatic logic [31:0] xr(logic [7:0] a);
      case (a)
         8'h00, 8'h04: return {24'h0, mct[a[2]]};
         8'h08: return ms;
         8'h0C: return me;
         8'h10, 8'h18: return mc[a[3]][31:0];
         8'h14, 8'h1C: return {16'h0, mc[a[3]][47:32]};
         8'h20: return {26'h0, mi[1], mi[0], !mo[1], !mo[0], mo[1], mo[0]};
         default: return 32'h0;
      endcase
   endfunction
   // weighted channel runs while the ratio keeps changing
   always @(posedge pclk) begin
      r = {$urandom, $urandom};
      tev = r[$bits(tev)-1:0];
      if (tev.issue_cnt == 2'h3)
         tev.issue_cnt = 2'h2;
      if ($urandom_range(7) != 0)
         tev.fexc_issue = 2'h0;
      evt <= run ? tev : '0;
      pc_valid <= run && r[63];
      pc <= 32'($urandom_range(15));
      if (run)
         ratio_code <= 3'($urandom_range(7));
   end
   task automatic complete_run;
      if (num_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic op(logic w, logic [7:0] a, logic [31:0] d);
      m.xfer(w, a, d, rd, er, to);
      if (to) begin
         num_errors++;
         complete_run();
      end
      `CHK("pslverr", !(a <= 8'h20 && a[1:0] == 2'h0), er)
      if (!w)
         `CHK("prdata", xr(a), rd)
   endtask
   task automatic chk_all;
      for (int i = 0; i < 11; i++)
         op(1'b0, ad[i], 32'h0);
   endtask
   initial begin
      void'($urandom(71762));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk_all();
      op(1'b1, `PEC_OFS_START, 32'h3);
      op(1'b1, `PEC_OFS_END, 32'h9);
      op(1'b1, `PEC_OFS_LO0, 32'hFFFF_FFFF);
      op(1'b1, 8'h24, 32'h1);
      for (int k = 0; k < 16; k++) begin
         op(1'b1, 8'h00, {23'h0, 1'b1, k[4:0], 1'b0, k[0], 1'b1});
         op(1'b1, 8'h04, {23'h0, 1'b1, k[4:0], 1'b1, ~k[0], 1'b1});
         run <= 1'b1;
         repeat (40) @(posedge pclk);
         run <= 1'b0;
         op(1'b1, 8'h00, 32'h0);
         op(1'b1, 8'h04, 32'h0);
         chk_all();
      end
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      chk_all();
      complete_run();
   end
endmodule // pec_counter_tb_top
